// >>> logic/ftrlr_pkg.sv
// package: register indices, reset values and carrier types
package ftrlr_pkg;
    // register indices; byte address is four times the index
    localparam logic [15:0] IX_HS_MIN = 16'h40a3;
    localparam logic [15:0] IX_LS_MASK = 16'h40a4;
    localparam logic [15:0] IX_TRIG = 16'h40a5;
    localparam logic [15:0] IX_OFS_H = 16'h40a6;
    localparam logic [15:0] IX_OFS_L = 16'h40a7;
    localparam logic [15:0] IX_STEP_H = 16'h40a8;
    localparam logic [15:0] IX_STEP_L = 16'h40a9;
    localparam logic [15:0] IX_ACC_H = 16'h40aa;
    localparam logic [15:0] IX_ACC_L = 16'h40ab;
    localparam logic [15:0] IX_RCNT = 16'h40ac;
    localparam logic [15:0] IX_SWSTEP = 16'h40ad;
    localparam logic [15:0] IX_COMP_H = 16'h40ae;
    localparam logic [15:0] IX_COMP_L = 16'h40af;
    localparam logic [15:0] IX_DMAX_H = 16'h40b0;
    localparam logic [15:0] IX_DMAX_L = 16'h40b1;
    localparam logic [15:0] IX_DMIN_H = 16'h40b2;
    localparam logic [15:0] IX_DMIN_L = 16'h40b3;
    localparam logic [15:0] IX_QMAX_H = 16'h40b4;
    localparam logic [15:0] IX_QMAX_L = 16'h40b5;
    localparam logic [15:0] IX_QMIN_H = 16'h40b6;
    localparam logic [15:0] IX_QMIN_L = 16'h40b7;
    localparam logic [15:0] IX_UD_H = 16'h40b8;
    localparam logic [15:0] IX_UD_L = 16'h40b9;
    localparam logic [15:0] IX_CTRL = 16'h40e0;
    localparam logic [15:0] IX_KLPF = 16'h40e1;
    // control register fields
    localparam int CTL_RAMP_EN = 0;
    localparam int CTL_ANG_SRC = 1;
    localparam int CTL_SHUNT = 2;
    localparam int CTL_OFS_SEL = 4;
    // reset values and limits
    localparam logic [14:0] OFS_RST = 15'h4000;
    localparam logic [6:0] SWSTEP_RST = 7'h00;
    localparam logic [7:0] KLPF_RST = 8'h40;
    localparam logic [15:0] EMF_MAX = 16'h7fff;
    localparam logic [3:0] SQRT_TOP = 4'hf;
    // shunt modes
    localparam logic [1:0] SH_SINGLE = 2'h0;
    localparam logic [1:0] SH_TRIPLE = 2'h3;
    // offset channel codes
    localparam logic [1:0] OSEL_A = 2'h1;
    localparam logic [1:0] OSEL_B = 2'h2;
    typedef enum logic [1:0] {PH_TRACK, PH_RAMP, PH_SLEW} ftrlr_phase_t;
    typedef struct packed
    {
        logic [15:0] speed;
        logic [15:0] angle;
        logic [15:0] forced_angle;
        logic [15:0] alpha;
        logic [15:0] beta;
        logic [15:0] d_raw;
        logic [15:0] q_raw;
    } ftrlr_est_t;
    typedef struct packed
    {
        logic [2:0] hs_gate;
        logic [2:0] ls_skip;
        logic [8:0] trig_ofs;
        logic trig_zero_vec;
    } ftrlr_samp_t;
endpackage

// >>> logic/ftrlr_sqrt.sv
// leaf: iterative square root of the summed squares of two axes
`timescale 1ns/10ps
module ftrlr_sqrt
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic start,
    input wire logic [15:0] axis_a,
    input wire logic [15:0] axis_b,
    output logic [15:0] root
);
    typedef struct packed
    {
        logic [31:0] sum;
        logic [15:0] acc;
        logic [3:0] bitpos;
        logic busy;
        logic [15:0] root;
    } ftrlr_sqrt_st_t;

    ftrlr_sqrt_st_t r;
    ftrlr_sqrt_st_t n;
    logic [15:0] trial;
    logic signed [31:0] sqa;
    logic signed [31:0] sqb;

    // one result bit per clock; a pwm period is far longer than 16 clocks
    always_comb
    begin
        n = r;
        trial = r.acc | (16'h0001 << r.bitpos);
        sqa = $signed(axis_a) * $signed(axis_a);
        sqb = $signed(axis_b) * $signed(axis_b);
        if (start)
        begin
            n.sum = 32'(sqa + sqb); // RULE13
            n.acc = 16'h0000;
            n.bitpos = ftrlr_pkg::SQRT_TOP;
            n.busy = 1'b1;
        end
        else if (r.busy)
        begin
            if (32'(trial) * 32'(trial) <= r.sum)
            begin
                n.acc = trial;
            end
            if (r.bitpos == 4'h0)
            begin
                n.busy = 1'b0;
                // saturate: both axes at full scale exceed the range
                n.root = (n.acc > ftrlr_pkg::EMF_MAX) ? ftrlr_pkg::EMF_MAX
                    : n.acc; // RULE13
            end
            n.bitpos = r.bitpos - 4'h1;
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            r <= '0;
        end
        else
        begin
            r <= n;
        end
    end

    assign root = r.root;

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    AST_EMF_RANGE: assert property ( // RULE13
        !r.root[15])
        else $error("back emf magnitude above range");
    CVR_SQRT_DONE: cover property (r.busy ##1 !r.busy);
endmodule

// >>> logic/ftrlr_clamp.sv
// leaf: registered signed clamp of a pi controller output
`timescale 1ns/10ps
module ftrlr_clamp
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic [15:0] raw,
    input wire logic [15:0] lower,
    input wire logic [15:0] upper,
    output logic [15:0] clamped
);
    typedef struct packed
    {
        logic [15:0] val;
    } ftrlr_clamp_st_t;

    ftrlr_clamp_st_t r;
    ftrlr_clamp_st_t n;

    // upper is checked first, so crossed limits give upper when raw is above it, else lower
    always_comb
    begin
        n = r;
        if ($signed(raw) > $signed(upper))
        begin
            n.val = upper; // RULE15
        end
        else if ($signed(raw) < $signed(lower))
        begin
            n.val = lower; // RULE16
        end
        else
        begin
            n.val = raw;
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            r <= '0;
        end
        else
        begin
            r <= n;
        end
    end

    assign clamped = r.val;

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    AST_CLAMP_RANGE: assert property ( // RULE16
        $signed(lower) <= $signed(upper) |=>
        $signed(r.val) <= $signed($past(upper)) &&
        $signed(r.val) >= $signed($past(lower)))
        else $error("pi output outside its limits");
endmodule

// >>> logic/ftrlr_regs.sv
// top: timing, ramp and limit register bank on an ahb-lite slave
// ---------------------------------------------------------------
// Overview of operation
// RULE1 - block high pulse shorter than minimum
// RULE2 - triple shunt: skip phase with short low
// RULE3 - zero delay samples at mode reference point
// RULE4 - single shunt delay is two's complement
// RULE5 - other modes: delay is sign and magnitude
// RULE6 - offset fifteen bits, top reads zero, midscale
// RULE7 - step accumulator adds acceleration each update
// RULE8 - acceleration upper half always zero
// RULE9 - ramp angle adds step upper half
// RULE10 - ramp ends after count times 256 ticks
// RULE11 - slew to new source by switch step
// RULE12 - low pass speed each tick, readable
// RULE13 - back emf magnitude is root of squares
// RULE14 - output angle is estimator plus compensation
// RULE15 - d output clamped by write-only limits
// RULE16 - q output clamped by read-write limits
// RULE17 - d pi result kept in d voltage
// RULE18 - three shared addresses read results instead
// RULE19 - offset select routes writes to channel
// RULE20 - ramp end picks source, clears enable
// RULE21 - high byte low address, low byte next
// RULE22 - updates once per pwm tick, reset defaults
// ---------------------------------------------------------------
//
// The AHB-Lite slave port was chosen for this implementation.
`timescale 1ns/10ps
module ftrlr_regs
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic pwm_tick,
    input wire ftrlr_pkg::ftrlr_est_t est,
    input wire logic [2:0][7:0] hs_on_time,
    input wire logic [2:0][7:0] ls_on_time,
    output ftrlr_pkg::ftrlr_samp_t samp,
    output logic [2:0][14:0] offset_cal,
    output logic [15:0] output_angle,
    output logic [15:0] d_axis_voltage,
    output logic [15:0] q_pi_out,
    output logic [15:0] bemf_magnitude
);
    typedef struct packed
    {
        logic [31:0] hrdata;
        logic hreadyout;
        logic rd_pend;
        logic wr_pend;
        logic aok;
        logic [15:0] aidx;
        logic [7:0] hs_min;
        logic [7:0] ls_mask;
        logic [7:0] trig;
        logic [2:0][14:0] ofs;
        logic [31:0] step;
        logic [15:0] acc;
        logic [7:0] rcnt;
        logic [6:0] swstep;
        logic [15:0] comp;
        logic [15:0] dmax;
        logic [15:0] dmin;
        logic [15:0] qmax;
        logic [15:0] qmin;
        logic [15:0] ud;
        logic ramp_force_angle_enable;
        logic angle_source_select;
        logic [1:0] csm;
        logic [1:0] offset_channel_select;
        logic [7:0] klpf;
        logic [15:0] rctr;
        ftrlr_pkg::ftrlr_phase_t phase;
        logic [15:0] ramp_ang;
        logic [15:0] angle;
        logic [15:0] filt;
        logic [15:0] omeg;
        ftrlr_pkg::ftrlr_samp_t samp;
    } ftrlr_st_t;

    ftrlr_st_t r;
    ftrlr_st_t n;
    logic aphase;
    logic [7:0] wb;
    logic [7:0] rdb;
    logic [1:0] osel;
    logic [2:0] hs_ok;
    logic [2:0] ls_sk;
    logic [15:0] tgt;
    logic [15:0] st;
    logic [15:0] dif;
    logic [15:0] lim;
    logic [15:0] cnt1;
    logic [31:0] stp;
    logic [8:0] mag;
    logic signed [16:0] dlt;
    logic signed [25:0] prd;
    logic [15:0] dclamp;
    logic [15:0] emf;

    // ---------------------------------------------------------------
    // per-phase pulse checks
    // ---------------------------------------------------------------
    for (genvar p = 0; p < 3; p++)
    begin : g_phase
        assign hs_ok[p] = hs_on_time[p] >= r.hs_min; // RULE1
        assign ls_sk[p] = ls_on_time[p] < r.ls_mask; // RULE2
    end

    // ---------------------------------------------------------------
    // estimator side leaves
    // ---------------------------------------------------------------
    ftrlr_sqrt u_sqrt
    (
        .hclk(hclk),
        .hresetn(hresetn),
        .start(pwm_tick),
        .axis_a(est.alpha),
        .axis_b(est.beta),
        .root(emf)
    );

    ftrlr_clamp u_dclamp
    (
        .hclk(hclk),
        .hresetn(hresetn),
        .raw(est.d_raw),
        .lower(r.dmin),
        .upper(r.dmax),
        .clamped(dclamp)
    );

    ftrlr_clamp u_qclamp
    (
        .hclk(hclk),
        .hresetn(hresetn),
        .raw(est.q_raw),
        .lower(r.qmin),
        .upper(r.qmax),
        .clamped(q_pi_out)
    );

    // ---------------------------------------------------------------
    // next state
    // ---------------------------------------------------------------
    always_comb
    begin
        n = r;
        wb = hwdata[7:0];
        aphase = hsel && htrans[1] && hready;
        osel = (r.offset_channel_select == ftrlr_pkg::OSEL_A) ? 2'h1
            : (r.offset_channel_select == ftrlr_pkg::OSEL_B) ? 2'h2 : 2'h0; // RULE19
        tgt = r.angle_source_select ? 16'(est.angle + r.comp) : est.forced_angle; // RULE14
        st = {8'h00, r.swstep, 1'b1};
        dif = 16'(tgt - r.angle);
        lim = {r.rcnt, 8'h00};
        cnt1 = 16'(r.rctr + 16'h0001);
        stp = r.step + {16'h0000, r.acc}; // RULE8
        mag = {2'h0, r.trig[6:0]};
        dlt = 17'($signed(est.speed) - $signed(r.filt));
        prd = dlt * $signed({1'b0, r.klpf});

        // sample timing, refreshed every clock
        n.samp.hs_gate = hs_ok; // RULE1
        n.samp.ls_skip = (r.csm == ftrlr_pkg::SH_TRIPLE) ? ls_sk
            : 3'h0; // RULE2
        n.samp.trig_zero_vec = r.csm != ftrlr_pkg::SH_SINGLE; // RULE3
        if (r.csm == ftrlr_pkg::SH_SINGLE)
        begin
            n.samp.trig_ofs = {r.trig[7], r.trig}; // RULE4
        end
        else
        begin
            n.samp.trig_ofs = r.trig[7] ? 9'(-mag) : mag; // RULE5
        end

        // estimator results, once per pwm tick
        if (pwm_tick)
        begin
            n.filt = 16'(r.filt + prd[23:8]); // RULE12
            n.omeg = est.speed[15] ? 16'h0000 : est.speed;
            n.ud = dclamp; // RULE17
        end

        // ramp, slew and tracking of the output angle
        case (r.phase)
            ftrlr_pkg::PH_TRACK:
            begin
                if (pwm_tick)
                begin
                    n.angle = tgt; // RULE14
                end
                if (r.ramp_force_angle_enable)
                begin
                    n.phase = ftrlr_pkg::PH_RAMP;
                    n.rctr = 16'h0000;
                    n.ramp_ang = r.angle;
                end
            end
            ftrlr_pkg::PH_RAMP:
            begin
                if (!r.ramp_force_angle_enable)
                begin
                    n.phase = ftrlr_pkg::PH_SLEW;
                end
                else if (pwm_tick)
                begin
                    n.step = stp; // RULE7
                    n.ramp_ang = 16'(r.ramp_ang + stp[31:16]); // RULE9
                    n.angle = n.ramp_ang;
                    n.rctr = cnt1;
                    if (cnt1 >= lim)
                    begin
                        n.ramp_force_angle_enable = 1'b0; // RULE10
                        n.phase = ftrlr_pkg::PH_SLEW; // RULE20
                    end
                end
            end
            ftrlr_pkg::PH_SLEW:
            begin
                if (pwm_tick)
                begin
                    if ($signed(dif) <= $signed(st) &&
                        $signed(dif) >= -$signed(st))
                    begin
                        n.angle = tgt;
                        n.phase = ftrlr_pkg::PH_TRACK;
                    end
                    else
                    begin
                        n.angle = dif[15] ? 16'(r.angle - st)
                            : 16'(r.angle + st); // RULE11
                    end
                end
            end
            default:
            begin
                n.phase = ftrlr_pkg::PH_TRACK;
            end
        endcase

        // bus write in its data phase; software wins over hardware
        if (r.wr_pend && r.aok)
        begin
            case (r.aidx) // RULE21
                ftrlr_pkg::IX_HS_MIN: n.hs_min = wb;
                ftrlr_pkg::IX_LS_MASK: n.ls_mask = wb;
                ftrlr_pkg::IX_TRIG: n.trig = wb;
                ftrlr_pkg::IX_OFS_H: n.ofs[osel][14:8] = wb[6:0]; // RULE6
                ftrlr_pkg::IX_OFS_L: n.ofs[osel][7:0] = wb; // RULE19
                ftrlr_pkg::IX_STEP_H: n.step[31:24] = wb; // RULE7
                ftrlr_pkg::IX_STEP_L: n.step[23:16] = wb;
                ftrlr_pkg::IX_ACC_H: n.acc[15:8] = wb; // RULE18
                ftrlr_pkg::IX_ACC_L: n.acc[7:0] = wb;
                ftrlr_pkg::IX_RCNT: n.rcnt = wb;
                ftrlr_pkg::IX_SWSTEP: n.swstep = wb[7:1]; // RULE11
                ftrlr_pkg::IX_COMP_H: n.comp[15:8] = wb;
                ftrlr_pkg::IX_COMP_L: n.comp[7:0] = wb;
                ftrlr_pkg::IX_DMAX_H: n.dmax[15:8] = wb; // RULE15
                ftrlr_pkg::IX_DMAX_L: n.dmax[7:0] = wb;
                ftrlr_pkg::IX_DMIN_H: n.dmin[15:8] = wb;
                ftrlr_pkg::IX_DMIN_L: n.dmin[7:0] = wb;
                ftrlr_pkg::IX_QMAX_H: n.qmax[15:8] = wb; // RULE16
                ftrlr_pkg::IX_QMAX_L: n.qmax[7:0] = wb;
                ftrlr_pkg::IX_QMIN_H: n.qmin[15:8] = wb;
                ftrlr_pkg::IX_QMIN_L: n.qmin[7:0] = wb;
                ftrlr_pkg::IX_UD_H: n.ud[15:8] = wb; // RULE17
                ftrlr_pkg::IX_UD_L: n.ud[7:0] = wb;
                ftrlr_pkg::IX_CTRL:
                begin
                    n.ramp_force_angle_enable = wb[ftrlr_pkg::CTL_RAMP_EN];
                    n.angle_source_select = wb[ftrlr_pkg::CTL_ANG_SRC];
                    n.csm = wb[ftrlr_pkg::CTL_SHUNT +: 2];
                    n.offset_channel_select = wb[ftrlr_pkg::CTL_OFS_SEL +: 2];
                end
                ftrlr_pkg::IX_KLPF: n.klpf = wb;
                default: n.klpf = r.klpf;
            endcase
        end

        // read mux; shared indices return results, not parameters
        rdb = 8'h00;
        if (r.aok)
        begin
            case (r.aidx) // RULE18
                ftrlr_pkg::IX_HS_MIN: rdb = r.hs_min;
                ftrlr_pkg::IX_LS_MASK: rdb = r.ls_mask;
                ftrlr_pkg::IX_TRIG: rdb = r.trig;
                ftrlr_pkg::IX_OFS_H: rdb = {1'b0, r.ofs[osel][14:8]}; // RULE6
                ftrlr_pkg::IX_OFS_L: rdb = r.ofs[osel][7:0];
                ftrlr_pkg::IX_STEP_H: rdb = r.step[31:24];
                ftrlr_pkg::IX_STEP_L: rdb = r.step[23:16];
                ftrlr_pkg::IX_ACC_H: rdb = r.filt[15:8]; // RULE12
                ftrlr_pkg::IX_ACC_L: rdb = r.filt[7:0];
                ftrlr_pkg::IX_RCNT: rdb = r.rcnt;
                ftrlr_pkg::IX_SWSTEP: rdb = {r.swstep, 1'b1}; // RULE11
                ftrlr_pkg::IX_COMP_H: rdb = emf[15:8]; // RULE13
                ftrlr_pkg::IX_COMP_L: rdb = emf[7:0];
                ftrlr_pkg::IX_DMAX_H: rdb = r.omeg[15:8];
                ftrlr_pkg::IX_DMAX_L: rdb = r.omeg[7:0];
                ftrlr_pkg::IX_QMAX_H: rdb = r.qmax[15:8];
                ftrlr_pkg::IX_QMAX_L: rdb = r.qmax[7:0];
                ftrlr_pkg::IX_QMIN_H: rdb = r.qmin[15:8];
                ftrlr_pkg::IX_QMIN_L: rdb = r.qmin[7:0];
                ftrlr_pkg::IX_UD_H: rdb = r.ud[15:8];
                ftrlr_pkg::IX_UD_L: rdb = r.ud[7:0];
                ftrlr_pkg::IX_CTRL:
                begin
                    rdb[ftrlr_pkg::CTL_RAMP_EN] = r.ramp_force_angle_enable;
                    rdb[ftrlr_pkg::CTL_ANG_SRC] = r.angle_source_select;
                    rdb[ftrlr_pkg::CTL_SHUNT +: 2] = r.csm;
                    rdb[ftrlr_pkg::CTL_OFS_SEL +: 2] = r.offset_channel_select;
                end
                ftrlr_pkg::IX_KLPF: rdb = r.klpf;
                default: rdb = 8'h00;
            endcase
        end

        // reads take one wait state so a write just before is seen
        n.wr_pend = aphase && hwrite;
        n.rd_pend = aphase && !hwrite;
        n.hreadyout = !(aphase && !hwrite);
        if (aphase)
        begin
            n.aidx = haddr[17:2];
            n.aok = haddr[31:18] == 14'h0000;
        end
        if (r.rd_pend)
        begin
            n.hrdata = {24'h000000, rdb};
        end
    end

    // ---------------------------------------------------------------
    // state register
    // ---------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            r <= '0; // RULE22
            r.hreadyout <= 1'b1;
            r.ofs <= {3{ftrlr_pkg::OFS_RST}}; // RULE6
            r.swstep <= ftrlr_pkg::SWSTEP_RST;
            r.klpf <= ftrlr_pkg::KLPF_RST;
        end
        else
        begin
            r <= n;
        end
    end

    assign hrdata = r.hrdata;
    assign hreadyout = r.hreadyout;
    assign hresp = 1'b0;
    assign samp = r.samp;
    assign offset_cal = r.ofs;
    assign output_angle = r.angle;
    assign d_axis_voltage = r.ud;
    assign bemf_magnitude = emf;

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    AST_HS_SUPPRESS: assert property ( // RULE1
        hs_on_time[0] < r.hs_min |=> !r.samp.hs_gate[0])
        else $error("narrow high side pulse not suppressed");
    AST_LS_SKIP: assert property ( // RULE2
        r.csm != ftrlr_pkg::SH_TRIPLE |=> r.samp.ls_skip == 3'h0)
        else $error("sample skipped outside triple shunt");
    AST_TRIG_ZERO: assert property ( // RULE3
        r.trig == 8'h00 |=> r.samp.trig_ofs == 9'h000)
        else $error("zero delay moved the sample point");
    AST_TRIG_TWOS: assert property ( // RULE4
        r.csm == ftrlr_pkg::SH_SINGLE && r.trig == 8'hfb
        |=> r.samp.trig_ofs == 9'h1fb)
        else $error("single shunt delay not two's complement");
    AST_TRIG_SMAG: assert property ( // RULE5
        r.csm != ftrlr_pkg::SH_SINGLE && r.trig == 8'h85
        |=> r.samp.trig_ofs == 9'h1fb)
        else $error("sign magnitude delay wrong");
    AST_OFS_READ: assert property ( // RULE6
        r.rd_pend && r.aidx == ftrlr_pkg::IX_OFS_H |=> !hrdata[7])
        else $error("offset top bit read as one");
    AST_OFS_ROUTE: assert property ( // RULE19
        r.wr_pend && r.aok && r.aidx == ftrlr_pkg::IX_OFS_L &&
        r.offset_channel_select == ftrlr_pkg::OSEL_B
        |=> r.ofs[2][7:0] == $past(hwdata[7:0]))
        else $error("offset write went to wrong channel");
    AST_RAMP_ACC: assert property ( // RULE7
        pwm_tick && r.ramp_force_angle_enable && r.phase == ftrlr_pkg::PH_RAMP && !r.wr_pend
        |=> r.step == $past(r.step) + {16'h0000, $past(r.acc)})
        else $error("step accumulator did not add acceleration");
    AST_RAMP_ANGLE: assert property ( // RULE9
        pwm_tick && r.ramp_force_angle_enable && r.phase == ftrlr_pkg::PH_RAMP && !r.wr_pend
        |=> r.ramp_ang == 16'($past(r.ramp_ang) + r.step[31:16]))
        else $error("ramp angle did not add step");
    AST_RAMP_END: assert property ( // RULE10
        pwm_tick && r.ramp_force_angle_enable && r.phase == ftrlr_pkg::PH_RAMP &&
        !r.wr_pend && cnt1 >= lim
        |=> r.phase == ftrlr_pkg::PH_SLEW && !r.ramp_force_angle_enable)
        else $error("ramp did not end at its count");
    AST_READ_WAIT: assert property ( // RULE21
        r.rd_pend |-> !hreadyout ##1 hreadyout)
        else $error("read wait state wrong");

    CVR_RAMP_DONE: cover property (
        r.phase == ftrlr_pkg::PH_RAMP ##1 r.phase == ftrlr_pkg::PH_SLEW);
    CVR_SLEW_DONE: cover property (
        r.phase == ftrlr_pkg::PH_SLEW ##1 r.phase == ftrlr_pkg::PH_TRACK);
    CVR_SHARED_RD: cover property (
        r.rd_pend && r.aidx == ftrlr_pkg::IX_ACC_H);
endmodule

// >>> sim/tb.sv
// testbench: register bank scenarios over ahb-lite
`timescale 1ns/10ps
module tb;
logic hclk, hresetn, hsel, hwrite, pwm_tick, hreadyout, hresp;
logic [31:0] haddr, hwdata, hrdata, rd;
logic [1:0] htrans;
logic [2:0] hsize;
ftrlr_pkg::ftrlr_est_t est;
ftrlr_pkg::ftrlr_samp_t samp;
logic [2:0][7:0] hs_on, ls_on;
logic [2:0][14:0] ofs;
logic [15:0] ang, ud, qo, bemf;
int err_count, n_tests;
ftrlr_regs uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .pwm_tick(pwm_tick),
    .est(est), .hs_on_time(hs_on), .ls_on_time(ls_on), .samp(samp),
    .offset_cal(ofs), .output_angle(ang), .d_axis_voltage(ud),
    .q_pi_out(qo), .bemf_magnitude(bemf));
// ----------------------------------------
// tasks
// ----------------------------------------
task chk(input logic [31:0] got, input logic [31:0] exp);
begin
    n_tests++;
    if (got !== exp)
    begin
        err_count++;
        $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
end
endtask
// one byte per word; the wait loops rely on the watchdog to end a hang
task bus(input logic [15:0] ix, input logic wr, input logic [7:0] wd);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {14'h0, ix, 2'h0};
    htrans <= 2'h2;
    hwrite <= wr;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h0, wd};
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd = hrdata;
endtask
task wr(input logic [15:0] ix, input logic [7:0] d);
    bus(ix, 1'b1, d);
endtask
task rdc(input logic [15:0] ix, input logic [31:0] exp);
    bus(ix, 1'b0, 8'h00);
    chk(rd, exp);
endtask
task tick;
    @(posedge hclk);
    pwm_tick <= 1'b1;
    @(posedge hclk);
    pwm_tick <= 1'b0;
    repeat (20) @(posedge hclk);
endtask
task wrap_up;
    $display("errors %0d comparisons %0d", err_count, n_tests);
    if (err_count == 0 && n_tests > 0)
        $display("STATUS OK");
    else
        $display("STATUS NOT OK");
    $finish;
endtask
// ----------------------------------------
// scenarios
// ----------------------------------------
task t_reset;
    rdc(ftrlr_pkg::IX_HS_MIN, 32'h0);
    rdc(ftrlr_pkg::IX_OFS_H, 32'h40);
    rdc(ftrlr_pkg::IX_SWSTEP, 32'h1);
    rdc(16'h4100, 32'h0);
    chk({17'h0, ofs[2]}, 32'h4000);
    chk({31'h0, hresp}, 32'h0);
endtask
task t_samp;
    wr(ftrlr_pkg::IX_HS_MIN, 8'h0a);
    wr(ftrlr_pkg::IX_LS_MASK, 8'h0a);
    wr(ftrlr_pkg::IX_CTRL, 8'h0c);
    wr(ftrlr_pkg::IX_TRIG, 8'h85);
    hs_on <= {8'h0b, 8'h0a, 8'h09};
    ls_on <= {8'h0b, 8'h0a, 8'h09};
    repeat (3) @(posedge hclk);
    chk({29'h0, samp.hs_gate}, 32'h6);
    chk({29'h0, samp.ls_skip}, 32'h1);
    chk({22'h0, samp.trig_zero_vec, samp.trig_ofs}, 32'h3fb);
    // single shunt reads the same byte as two's complement
    wr(ftrlr_pkg::IX_CTRL, 8'h00);
    repeat (3) @(posedge hclk);
    chk({22'h0, samp.trig_zero_vec, samp.trig_ofs}, 32'h185);
    chk({29'h0, samp.ls_skip}, 32'h0);
endtask
task t_ofs;
    wr(ftrlr_pkg::IX_CTRL, 8'h10);
    wr(ftrlr_pkg::IX_OFS_H, 8'hff);
    wr(ftrlr_pkg::IX_OFS_L, 8'h12);
    // the write lands on the edge the task returns at; look once settled
    @(negedge hclk);
    chk({17'h0, ofs[1]}, 32'h7f12);
    chk({17'h0, ofs[0]}, 32'h4000);
    rdc(ftrlr_pkg::IX_OFS_H, 32'h7f);
    wr(ftrlr_pkg::IX_CTRL, 8'h20);
    wr(ftrlr_pkg::IX_OFS_L, 8'h34);
    @(negedge hclk);
    chk({17'h0, ofs[2]}, 32'h4034);
endtask
task t_q;
    est.q_raw <= 16'h7000;
    wr(ftrlr_pkg::IX_QMAX_H, 8'h01);
    wr(ftrlr_pkg::IX_QMAX_L, 8'h00);
    wr(ftrlr_pkg::IX_QMIN_H, 8'hff);
    wr(ftrlr_pkg::IX_QMIN_L, 8'h00);
    repeat (3) @(posedge hclk);
    chk({16'h0, qo}, 32'h0100);
    est.q_raw <= 16'h8000;
    repeat (3) @(posedge hclk);
    chk({16'h0, qo}, 32'hff00);
    rdc(ftrlr_pkg::IX_QMIN_H, 32'hff);
endtask
task t_ramp;
    est.alpha <= 16'h0003;
    est.beta <= 16'h0004;
    est.speed <= 16'h0100;
    est.d_raw <= 16'h0200;
    wr(ftrlr_pkg::IX_DMAX_H, 8'h01);
    wr(ftrlr_pkg::IX_STEP_L, 8'h10);
    wr(ftrlr_pkg::IX_CTRL, 8'h01);
    tick();
    chk({16'h0, ang}, 32'h0010);
    rdc(ftrlr_pkg::IX_CTRL, 32'h0);
    chk({16'h0, bemf}, 32'h5);
    rdc(ftrlr_pkg::IX_ACC_L, 32'h40);
    rdc(ftrlr_pkg::IX_DMAX_H, 32'h01);
    chk({16'h0, ud}, 32'h0100);
    rdc(ftrlr_pkg::IX_UD_H, 32'h01);
    // slew toward forced target 0 by a step of one per tick
    tick();
    chk({16'h0, ang}, 32'h000f);
endtask
// ----------------------------------------
// main sequence
// ----------------------------------------
initial
begin
    hclk = 1'b0;
    forever #25 hclk = ~hclk;
end
initial
begin
    repeat (20000) @(posedge hclk);
    err_count++;
    wrap_up();
end
initial
begin
    hresetn = 1'b0;
    {hsel, hwrite, pwm_tick} = 3'h0;
    haddr = 32'h0;
    hwdata = 32'h0;
    htrans = 2'h0;
    hsize = 3'h2;
    est = '0;
    hs_on = '0;
    ls_on = '0;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset();
    t_samp();
    t_ofs();
    t_q();
    t_ramp();
    wrap_up();
end
endmodule
